//--- src/ref_defines.vh
`ifndef REF_DEFINES_VH
`define REF_DEFINES_VH
// ********************************************
// register indices (byte address = 4 * index)
// ********************************************
`define REF_IDX_W            6
`define REF_IDX_BASE_LO      6'h06
`define REF_IDX_BASE_HI      6'h07
`define REF_IDX_EXT          6'h0b
`define REF_IDX_FLT          6'h0d
`define REF_IDX_CMD          6'h3e
`define REF_IDX_RESP         6'h3f
// ********************************************
// register word fields
// ********************************************
`define REF_RW_BIT           15
`define REF_SEL_HI           14
`define REF_SEL_LO           9
`define REF_RSV_EXT_BIT      8
`define REF_EN_HI            7
`define REF_EN_LO            0
`define REF_CUT_HI           1
`define REF_CUT_LO           0
// ********************************************
// reset values
// ********************************************
`define REF_EXT_RST          16'h1600
`define REF_FLT_RST          16'h1a00
`define REF_EN_RST           8'h00
`define REF_CUT_RST          2'h0
// ********************************************
// cutoff codes and frequencies in khz
// ********************************************
`define REF_CUT_39K          2'h0
`define REF_CUT_15K          2'h1
`define REF_CUT_376K         2'h2
`define REF_CUT_UNDEF        2'h3
`define REF_KHZ_39           9'h027
`define REF_KHZ_15           9'h00f
`define REF_KHZ_376          9'h178
// ********************************************
// base range codes and full scale in 0.1 v
// ********************************************
`define REF_RNG_10V_A        2'h0
`define REF_RNG_2V5          2'h1
`define REF_RNG_5V           2'h2
`define REF_RNG_10V_B        2'h3
`define REF_FS_10V           8'h64
`define REF_FS_5V            8'h32
`define REF_FS_2V5           8'h19
`define REF_FS_10V_X         8'h78
`define REF_FS_5V_X          8'h3c
`define REF_FS_2V5_X         8'h1e
`endif

//--- src/ref_regs.v
// Functional notes
// - word bit 15: zero reads, one writes
// - bits 14-9 carry target register select
// - extension register at 0xb, resets 0x1600
// - filter register at 0xd, resets 0x1a00
// - reserved bits read zero, ignore writes
// - bit n widens channel n by 20%
// - channels 0-3 base 0x06, 4-7 0x07
// - cutoff codes: 39k, 15k, 376k
// - one cutoff shared by all channels
// - base codes: 00/11 10v, 01 2.5v, 10 5v
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ref_defines.vh"

// ********************************************
// one channel full scale
// ********************************************
module ref_chan
(
   // clock and reset
   input  wire       clk,
   input  wire       rst_b,
   input  wire       ce,
   // control
   input  wire [1:0] base_range,
   input  wire       widen,
   // result
   output reg  [7:0] full_scale_q
);
   reg [7:0] full_scale_d;

   always @*
   begin
      case (base_range)
         `REF_RNG_2V5:
         begin
            full_scale_d = widen ? `REF_FS_2V5_X : `REF_FS_2V5;
         end
         `REF_RNG_5V:
         begin
            full_scale_d = widen ? `REF_FS_5V_X : `REF_FS_5V;
         end
         default:
         begin
            full_scale_d = widen ? `REF_FS_10V_X : `REF_FS_10V;
         end
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         full_scale_q <= 8'h00;
      end
      else if (ce)
      begin
         full_scale_q <= full_scale_d;
      end
   end
endmodule // ref_chan

// ********************************************
// register bank
// ********************************************
module ref_regs
(
   // clock and reset
   input  wire        clk,
   input  wire        rst_b,
   input  wire        ce,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // base ranges from elsewhere
   input  wire [7:0]  base_range_lo_i,
   input  wire [7:0]  base_range_hi_i,
   // control outputs
   output wire [7:0]  widen_enable_o,
   output wire [1:0]  cutoff_select_field_o,
   output reg  [1:0]  cutoff_code_o,
   output reg  [8:0]  cutoff_khz_o,
   output wire [63:0] full_scale_dv_o
);
   // ********************************************
   // state
   // ********************************************
   reg  [7:0]  widen_q;
   reg  [7:0]  widen_d;
   reg  [1:0]  cut_q;
   reg  [1:0]  cut_d;
   reg  [15:0] resp_q;
   reg  [15:0] resp_d;
   reg  [1:0]  cut_eff;
   reg  [8:0]  khz_d;
   wire [5:0]  idx;
   wire        req;
   wire        bus_wr;
   wire        cmd_go;
   wire        cmd_wr;
   wire        cmd_rd;
   wire [5:0]  cmd_sel;
   wire [15:0] base_pair;
   wire        ext_bus_wr;
   wire        flt_bus_wr;
   wire        ext_cmd_wr;
   wire        flt_cmd_wr;
   wire [15:0] ext_word;
   wire [15:0] flt_word;

   assign idx       = wb_adr_i[7:2];
   assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr    = req & wb_we_i;
   assign cmd_go    = bus_wr & (idx == `REF_IDX_CMD) & (wb_sel_i[1:0] == 2'h3);
   assign cmd_wr    = cmd_go & wb_dat_i[`REF_RW_BIT];
   assign cmd_rd    = cmd_go & ~wb_dat_i[`REF_RW_BIT];
   assign cmd_sel   = wb_dat_i[`REF_SEL_HI:`REF_SEL_LO];
   assign base_pair = {base_range_hi_i, base_range_lo_i};

   // ********************************************
   // write strobes
   // ********************************************
   assign ext_bus_wr = bus_wr & (idx == `REF_IDX_EXT) & wb_sel_i[0];
   assign flt_bus_wr = bus_wr & (idx == `REF_IDX_FLT) & wb_sel_i[0];
   assign ext_cmd_wr = cmd_wr & (cmd_sel == `REF_IDX_EXT);
   assign flt_cmd_wr = cmd_wr & (cmd_sel == `REF_IDX_FLT);

   // ********************************************
   // register word as seen by a read
   // ********************************************
   function [15:0] rd_word;
      input [5:0] sel;
      input [7:0] en;
      input [1:0] cut;
      begin
         case (sel)
            `REF_IDX_EXT:
            begin
               rd_word = {1'h0, sel, 1'h0, en};
            end
            `REF_IDX_FLT:
            begin
               rd_word = {1'h0, sel, 7'h00, cut};
            end
            default:
            begin
               rd_word = 16'h0000;
            end
         endcase
      end
   endfunction

   assign ext_word = rd_word(`REF_IDX_EXT, widen_q, cut_q);
   assign flt_word = rd_word(`REF_IDX_FLT, widen_q, cut_q);

   // ********************************************
   // next register values
   // ********************************************
   always @*
   begin
      widen_d = widen_q;
      cut_d   = cut_q;
      resp_d  = resp_q;
      if (ext_bus_wr)
      begin
         widen_d = wb_dat_i[`REF_EN_HI:`REF_EN_LO];
      end
      if (flt_bus_wr)
      begin
         cut_d = wb_dat_i[`REF_CUT_HI:`REF_CUT_LO];
      end
      if (ext_cmd_wr)
      begin
         widen_d = wb_dat_i[`REF_EN_HI:`REF_EN_LO];
      end
      if (flt_cmd_wr)
      begin
         cut_d = wb_dat_i[`REF_CUT_HI:`REF_CUT_LO];
      end
      if (cmd_rd)
      begin
         resp_d = rd_word(cmd_sel, widen_q, cut_q);
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         widen_q <= `REF_EN_RST;
         cut_q   <= `REF_CUT_RST;
         resp_q  <= 16'h0000;
      end
      else if (ce)
      begin
         widen_q <= widen_d;
         cut_q   <= cut_d;
         resp_q  <= resp_d;
      end
   end

   // ********************************************
   // wishbone answer
   // ********************************************
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h00000000;
      end
      else if (ce)
      begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
         begin
            case (idx)
               `REF_IDX_EXT:
               begin
                  wb_dat_o <= {16'h0000, ext_word};
               end
               `REF_IDX_FLT:
               begin
                  wb_dat_o <= {16'h0000, flt_word};
               end
               `REF_IDX_RESP:
               begin
                  wb_dat_o <= {16'h0000, resp_q};
               end
               default:
               begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // ********************************************
   // shared cutoff
   // ********************************************
   always @*
   begin
      case (cut_q)
         `REF_CUT_15K:
         begin
            cut_eff = `REF_CUT_15K;
            khz_d   = `REF_KHZ_15;
         end
         `REF_CUT_376K:
         begin
            cut_eff = `REF_CUT_376K;
            khz_d   = `REF_KHZ_376;
         end
         default:
         begin
            cut_eff = `REF_CUT_39K;
            khz_d   = `REF_KHZ_39;
         end
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         cutoff_code_o <= `REF_CUT_39K;
         cutoff_khz_o  <= `REF_KHZ_39;
      end
      else if (ce)
      begin
         cutoff_code_o <= cut_eff;
         cutoff_khz_o  <= khz_d;
      end
   end

   assign widen_enable_o        = widen_q;
   assign cutoff_select_field_o = cut_q;

   // ********************************************
   // per channel full scale
   // ********************************************
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_chan
         ref_chan u_chan
         (
            .clk          (clk),
            .rst_b        (rst_b),
            .ce           (ce),
            .base_range   (base_pair[2*gi+1:2*gi]),
            .widen        (widen_q[gi]),
            .full_scale_q (full_scale_dv_o[8*gi+7:8*gi])
         );
      end
   endgenerate
endmodule // ref_regs

//--- test/ref_regs_assertions.sv
`timescale 1ns/1ps
module ref_regs_chk
(
   // clock and reset
   input logic        clk,
   input logic        rst_b,
   input logic        ce,
   // wishbone
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [7:0]  wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   // ranges and controls
   input logic [7:0]  base_range_lo_i,
   input logic [7:0]  base_range_hi_i,
   input logic [7:0]  widen_enable_o,
   input logic [1:0]  cutoff_select_field_o,
   input logic [1:0]  cutoff_code_o,
   input logic [8:0]  cutoff_khz_o,
   input logic [63:0] full_scale_dv_o
);
   // ********************************************
   // bus and control properties
   // ********************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire rd = wb_ack_o && !wb_we_i;
   function automatic logic [7:0] fsv(input logic [1:0] c, input logic w);
      fsv = (c == 2'h1) ? (w ? 8'h1e : 8'h19) : (c == 2'h2) ? (w ? 8'h3c : 8'h32) :
            (w ? 8'h78 : 8'h64);
   endfunction
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   sequence s_wr_ext;
      s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h2c);
   endsequence
   sequence s_cmd_ext;
      s_req ##0 (wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i == 8'hf8
                 && wb_dat_i[15:9] == 7'h4b);
   endsequence
   sequence s_wr_flt;
      s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h34);
   endsequence
   chk_ack_timing: assert property (s_req |=> wb_ack_o) else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack held");
   chk_flt_write: assert property (s_wr_flt |=>
      cutoff_select_field_o == $past(wb_dat_i[1:0])) else $error("filter write lost");
   chk_ext_read: assert property (rd && wb_adr_i == 8'h2c |-> wb_dat_o[31:8] == 24'h16)
      else $error("ext read bad");
   chk_flt_read: assert property (rd && wb_adr_i == 8'h34 |-> wb_dat_o[31:2] == 30'h680)
      else $error("filter read bad");
   chk_widen_write: assert property (s_wr_ext |=> widen_enable_o == $past(wb_dat_i[7:0]))
      else $error("widen write lost");
   chk_cmd_write: assert property (s_cmd_ext |=> widen_enable_o == $past(wb_dat_i[7:0]))
      else $error("command write lost");
   chk_cut_code: assert property ($past(rst_b) && $past(ce) |-> cutoff_code_o ==
      ($past(cutoff_select_field_o) == 2'h3 ? 2'h0 : $past(cutoff_select_field_o)))
      else $error("cutoff code bad");
   chk_cut_khz: assert property ($past(rst_b) && $past(ce) |-> cutoff_khz_o ==
      ($past(cutoff_select_field_o) == 2'h1 ? 9'h00f :
      $past(cutoff_select_field_o) == 2'h2 ? 9'h178 : 9'h027)) else $error("khz bad");
   chk_full_scale: assert property ($past(rst_b) && $past(ce) |-> full_scale_dv_o[7:0] ==
      fsv($past(base_range_lo_i[1:0]), $past(widen_enable_o[0])) && full_scale_dv_o[63:56]
      == fsv($past(base_range_hi_i[7:6]), $past(widen_enable_o[7]))) else $error("fs bad");
endmodule // ref_regs_chk

bind ref_regs ref_regs_chk u_chk (.clk, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .base_range_lo_i, .base_range_hi_i,
   .widen_enable_o, .cutoff_select_field_o, .cutoff_code_o, .cutoff_khz_o, .full_scale_dv_o);

//--- test/tb_ref_regs.sv
`timescale 1ns/1ps
module tb_ref_regs;
   // ********************************************
   // stimulus and checking
   // ********************************************
   logic        clk = 0, rst_b = 0, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
   logic [7:0]  wb_adr_i = 0, base_range_lo_i = 0, base_range_hi_i = 0, widen_enable_o;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 0, wb_dat_o, exp_q[$];
   logic [1:0]  cutoff_select_field_o, cutoff_code_o;
   logic [8:0]  cutoff_khz_o;
   logic [63:0] full_scale_dv_o;
   logic [15:0] r = 16'h19ee;
   int          n_mismatch = 0, samples_checked = 0, cyc_n = 0;
   always #5 clk = ~clk;
   ref_regs uut (.clk, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .base_range_lo_i, .base_range_hi_i, .widen_enable_o,
      .cutoff_select_field_o, .cutoff_code_o, .cutoff_khz_o, .full_scale_dv_o);
   task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task print_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [7:0] fsv(input logic [1:0] c, input logic w);
      return (c == 2'h1) ? (w ? 8'h1e : 8'h19) : (c == 2'h2) ? (w ? 8'h3c : 8'h32) :
             (w ? 8'h78 : 8'h64);
   endfunction
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      if (!w)
         exp_q.push_back(e);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk);
   endtask
   always @(posedge clk)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check(wb_dat_o, exp_q.pop_front(), "read data");
   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n > 2000)
      begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      wb(0, 8'h2c, 0, 32'h1600);
      wb(0, 8'h34, 0, 32'h1a00);
      for (int i = 0; i < 6; i++)
      begin
         r = lfsr(r);
         base_range_lo_i <= r[7:0];
         base_range_hi_i <= r[15:8];
         wb(1, 8'h2c, {r, r}, 0);
         wb(0, 8'h2c, 0, {24'h16, r[7:0]});
         check(widen_enable_o, r[7:0], "widen");
         for (int c = 0; c < 8; c++)
            check(full_scale_dv_o[8*c+:8], fsv(c < 4 ? r[2*c+:2] : r[2*c+:2], r[c]), "fs");
      end
      for (int c = 0; c < 4; c++)
      begin
         wb(1, 8'h34, 32'hfffffffc | c, 0);
         wb(0, 8'h34, 0, 32'h1a00 | c);
         check(cutoff_select_field_o, c, "cutoff field");
         check(cutoff_code_o, c == 3 ? 0 : c, "cutoff code");
         check(cutoff_khz_o, c == 1 ? 15 : c == 2 ? 376 : 39, "cutoff khz");
      end
      wb(1, 8'hf8, 32'h97a5, 0);
      wb(0, 8'h2c, 0, 32'h16a5);
      wb(1, 8'hf8, 32'h1a00, 0);
      wb(0, 8'hfc, 0, 32'h1a03);
      wb(1, 8'hf8, 32'h3000, 0);
      wb(0, 8'hfc, 0, 0);
      wb(1, 8'h40, 32'hffff, 0);
      wb(0, 8'h40, 0, 0);
      wb_sel_i <= 4'he;
      wb(1, 8'h2c, 32'h00ff, 0);
      wb_sel_i <= 4'hf;
      wb(0, 8'h2c, 0, 32'h16a5);
      rst_b <= 0;
      @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      wb(0, 8'h2c, 0, 32'h1600);
      wb(0, 8'h34, 0, 32'h1a00);
      check(cutoff_select_field_o, 0, "field after reset");
      check(widen_enable_o, 0, "widen after reset");
      base_range_lo_i <= 8'h00;
      repeat (2) @(posedge clk);
      ce <= 0;
      base_range_lo_i <= 8'h01;
      repeat (3) @(posedge clk);
      check(full_scale_dv_o[7:0], 8'h64, "fs frozen");
      ce <= 1;
      repeat (2) @(posedge clk);
      check(full_scale_dv_o[7:0], 8'h19, "fs resumed");
      print_verdict;
   end
endmodule // tb_ref_regs
